//--- rtl/tcr_pkg.sv
`default_nettype none
package tcr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_CH_MODE = 8'h18;
    localparam logic [7:0] OFF_ENABLE_POLARITY = 8'h20;
    localparam logic [7:0] OFF_COUNTER = 8'h24;
    localparam logic [7:0] OFF_PRESCALER = 8'h28;
    localparam logic [7:0] OFF_RELOAD = 8'h2C;
    localparam logic [7:0] OFF_REPETITION = 8'h30;
    localparam logic [7:0] OFF_CH1_VALUE = 8'h34;
    localparam logic [7:0] OFF_CH2_VALUE = 8'h38;
    // Enable/polarity register fields
    localparam int CH1_EN_BIT = 0;
    localparam int CH1_POL_BIT = 1;
    localparam int CH1_COMP_EN_BIT = 2;
    localparam int CH1_COMP_POL_BIT = 3;
    localparam int CH2_EN_BIT = 4;
    localparam int CH2_POL_BIT = 5;
    localparam int CH2_COMP_POL_BIT = 7;
    localparam logic [7:0] ENPOL_WRITABLE = 8'hBF;
    // Control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_LOCK_LSB = 8;
    localparam logic [1:0] LOCK_LEVEL_2 = 2'h2;
    // Channel mode register fields
    localparam int CH1_DIR_LSB = 0;
    localparam int CH2_DIR_LSB = 8;
    localparam logic [1:0] DIR_OUTPUT = 2'h0;
    localparam logic [1:0] DIR_OWN_PIN = 2'h1;
    localparam logic [1:0] DIR_OTHER_PIN = 2'h2;
    // Interrupt status fields
    localparam int STAT_UPDATE_BIT = 0;
    localparam int STAT_CAP1_BIT = 1;
    localparam int STAT_CAP2_BIT = 2;
    localparam int STAT_WIDTH = 3;
    // Capture sense codes (complementary, main)
    localparam logic [1:0] SENSE_FALLING = 2'h1;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    // Reset values
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] ENPOL_RESET = 8'h00;
    localparam logic [7:0] REPETITION_RESET = 8'h00;
endpackage
`default_nettype wire

//--- rtl/tcr_timer.sv
// Contract
// - Output mode: enable bit gates ch1 compare output
// - Input mode: enable bit gates ch1 capture
// - Polarity bit sets ch1 output active level
// - Input sense 00 rising, 01 inverted
// - Sense 11 both edges; not in encoder
// - Bit 2 enables ch1 complementary output
// - Bit 3 sets complementary output active level
// - Lock level 2/3 freezes complementary polarity
// - Channel 2 bits mirror channel 1, except bit 6: no ch2 complementary output
// - Counter ticks at clock over prescale+1
// - Reload resets FFFF; zero stops counter
// - Repetition reaching zero updates, then reloads
// - New repetition value applies at update
// - Direction code 00 means output
// - Capture latches counter into value register
`timescale 1ns/1ps
`default_nettype none
module tcr_timer (
    input wire logic clock, // 100 MHz
    input wire logic reset, // Synchronous, active high
    input wire logic [7:0] address, // Byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte lanes
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    input wire logic input_pin1, // Timer input 1
    input wire logic input_pin2, // Timer input 2
    input wire logic trigger_in, // Internal trigger source
    output logic ch1_compare_out, // Channel 1 output
    output logic ch1_compare_out_n, // Channel 1 complementary output
    output logic ch2_compare_out, // Channel 2 output
    output logic irq // Level interrupt
);
    logic wait_q;
    logic [31:0] rdata_q;
    logic [7:0] enpol_q;
    logic [15:0] count_q;
    logic [15:0] prescale_value_q;
    logic [15:0] prescale_cnt_q;
    logic [15:0] reload_value_q;
    logic [7:0] repeat_count_value_q;
    logic [7:0] repeat_left_q;
    logic [15:0] ch1_value_q;
    logic [15:0] ch2_value_q;
    logic run_q;
    logic [1:0] lock_q;
    logic [1:0] ch1_direction_select_q;
    logic [1:0] ch2_direction_select_q;
    logic [tcr_pkg::STAT_WIDTH-1:0] status_q;
    logic [tcr_pkg::STAT_WIDTH-1:0] mask_q;
    logic out1_q;
    logic out1n_q;
    logic out2_q;
    logic irq_q;
    logic in1_prev_q;
    logic in2_prev_q;
    logic trig_prev_q;

    logic wr_go;
    logic rd_go;
    logic counting;
    logic counter_tick;
    logic wrap;
    logic update_event;
    logic ref1;
    logic ref2;
    logic cap1;
    logic cap2;
    logic [tcr_pkg::STAT_WIDTH-1:0] events;
    logic [31:0] rmux;

    // Merge byte lanes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Pick the capture source from the direction code
    function automatic logic [1:0] pick_src(input logic [1:0] dir, input logic [1:0] own,
                                            input logic [1:0] other, input logic [1:0] trc);
        if (dir == tcr_pkg::DIR_OWN_PIN) begin
            pick_src = own;
        end else if (dir == tcr_pkg::DIR_OTHER_PIN) begin
            pick_src = other;
        end else begin
            pick_src = trc;
        end
    endfunction

    // Edge detect by sense code; src is {previous, current}
    function automatic logic edge_hit(input logic [1:0] sense, input logic [1:0] src);
        logic rise;
        logic fall;
        rise = !src[1] && src[0];
        fall = src[1] && !src[0];
        if (sense == tcr_pkg::SENSE_BOTH) begin
            edge_hit = rise || fall;
        end else if (sense == tcr_pkg::SENSE_FALLING) begin
            edge_hit = fall;
        end else begin
            edge_hit = rise;
        end
    endfunction

    // Bus answer: one wait cycle, then waitrequest low for one cycle
    assign wr_go = write && !wait_q;
    assign rd_go = read && wait_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((read || write) && wait_q);
        end
    end

    always_comb begin
        rmux = 32'h0000_0000;
        unique case (address)
            tcr_pkg::OFF_CONTROL: begin
                rmux[tcr_pkg::CTRL_RUN_BIT] = run_q;
                rmux[tcr_pkg::CTRL_LOCK_LSB +: 2] = lock_q;
            end
            tcr_pkg::OFF_IRQ_MASK: rmux[tcr_pkg::STAT_WIDTH-1:0] = mask_q;
            tcr_pkg::OFF_IRQ_STATUS: rmux[tcr_pkg::STAT_WIDTH-1:0] = status_q;
            tcr_pkg::OFF_CH_MODE: begin
                rmux[tcr_pkg::CH1_DIR_LSB +: 2] = ch1_direction_select_q;
                rmux[tcr_pkg::CH2_DIR_LSB +: 2] = ch2_direction_select_q;
            end
            tcr_pkg::OFF_ENABLE_POLARITY: rmux[7:0] = enpol_q;
            tcr_pkg::OFF_COUNTER: rmux[15:0] = count_q;
            tcr_pkg::OFF_PRESCALER: rmux[15:0] = prescale_value_q;
            tcr_pkg::OFF_RELOAD: rmux[15:0] = reload_value_q;
            tcr_pkg::OFF_REPETITION: rmux[7:0] = repeat_count_value_q;
            tcr_pkg::OFF_CH1_VALUE: rmux[15:0] = ch1_value_q;
            tcr_pkg::OFF_CH2_VALUE: rmux[15:0] = ch2_value_q;
            default: rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_go) begin
            rdata_q <= rmux;
        end
    end

    // Control, mode and interrupt mask registers
    always_ff @(posedge clock) begin
        if (reset) begin
            run_q <= 1'b0;
            lock_q <= 2'h0;
            mask_q <= '0;
            ch1_direction_select_q <= tcr_pkg::DIR_OUTPUT;
            ch2_direction_select_q <= tcr_pkg::DIR_OUTPUT;
        end else if (wr_go) begin
            if (address == tcr_pkg::OFF_CONTROL) begin
                if (byteenable[0]) begin
                    run_q <= writedata[tcr_pkg::CTRL_RUN_BIT];
                end
                if (byteenable[1]) begin
                    lock_q <= writedata[tcr_pkg::CTRL_LOCK_LSB +: 2];
                end
            end
            if (address == tcr_pkg::OFF_IRQ_MASK && byteenable[0]) begin
                mask_q <= writedata[tcr_pkg::STAT_WIDTH-1:0];
            end
            // Direction may change only while the channel is disabled
            if (address == tcr_pkg::OFF_CH_MODE) begin
                if (byteenable[0] && !enpol_q[tcr_pkg::CH1_EN_BIT]) begin
                    ch1_direction_select_q <= writedata[tcr_pkg::CH1_DIR_LSB +: 2];
                end
                if (byteenable[1] && !enpol_q[tcr_pkg::CH2_EN_BIT]) begin
                    ch2_direction_select_q <= writedata[tcr_pkg::CH2_DIR_LSB +: 2];
                end
            end
        end
    end

    // Enable/polarity register with lock on complementary polarity
    always_ff @(posedge clock) begin
        if (reset) begin
            enpol_q <= tcr_pkg::ENPOL_RESET;
        end else if (wr_go && address == tcr_pkg::OFF_ENABLE_POLARITY && byteenable[0]) begin
            enpol_q <= writedata[7:0] & tcr_pkg::ENPOL_WRITABLE;
            if (lock_q >= tcr_pkg::LOCK_LEVEL_2) begin
                enpol_q[tcr_pkg::CH1_COMP_POL_BIT] <= enpol_q[tcr_pkg::CH1_COMP_POL_BIT];
                enpol_q[tcr_pkg::CH2_COMP_POL_BIT] <= enpol_q[tcr_pkg::CH2_COMP_POL_BIT];
            end
        end
    end

    // Prescaler, reload and repetition settings
    always_ff @(posedge clock) begin
        if (reset) begin
            prescale_value_q <= tcr_pkg::ZERO16;
            reload_value_q <= tcr_pkg::RELOAD_RESET;
            repeat_count_value_q <= tcr_pkg::REPETITION_RESET;
        end else if (wr_go) begin
            if (address == tcr_pkg::OFF_PRESCALER) begin
                prescale_value_q <= merge16(prescale_value_q, writedata, byteenable);
            end
            if (address == tcr_pkg::OFF_RELOAD) begin
                reload_value_q <= merge16(reload_value_q, writedata, byteenable);
            end
            if (address == tcr_pkg::OFF_REPETITION && byteenable[0]) begin
                repeat_count_value_q <= writedata[7:0];
            end
        end
    end

    // Counter runs only when enabled and the reload value is non-zero
    assign counting = run_q && (reload_value_q != tcr_pkg::ZERO16);
    assign counter_tick = counting && (prescale_cnt_q >= prescale_value_q);
    assign wrap = counter_tick && (count_q >= reload_value_q);
    assign update_event = wrap && (repeat_left_q == 8'h00);

    always_ff @(posedge clock) begin
        if (reset) begin
            prescale_cnt_q <= tcr_pkg::ZERO16;
        end else if (!counting || counter_tick) begin
            prescale_cnt_q <= tcr_pkg::ZERO16;
        end else begin
            prescale_cnt_q <= prescale_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            count_q <= tcr_pkg::ZERO16;
        end else if (wr_go && address == tcr_pkg::OFF_COUNTER) begin
            count_q <= merge16(count_q, writedata, byteenable);
        end else if (wrap) begin
            count_q <= tcr_pkg::ZERO16;
        end else if (counter_tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            repeat_left_q <= tcr_pkg::REPETITION_RESET;
        end else if (update_event) begin
            repeat_left_q <= repeat_count_value_q;
        end else if (wrap) begin
            repeat_left_q <= repeat_left_q - 8'h01;
        end
    end

    // Capture events
    assign cap1 = (ch1_direction_select_q != tcr_pkg::DIR_OUTPUT)
        && enpol_q[tcr_pkg::CH1_EN_BIT]
        && edge_hit({enpol_q[tcr_pkg::CH1_COMP_POL_BIT], enpol_q[tcr_pkg::CH1_POL_BIT]},
                    pick_src(ch1_direction_select_q, {in1_prev_q, input_pin1},
                             {in2_prev_q, input_pin2}, {trig_prev_q, trigger_in}));
    assign cap2 = (ch2_direction_select_q != tcr_pkg::DIR_OUTPUT)
        && enpol_q[tcr_pkg::CH2_EN_BIT]
        && edge_hit({enpol_q[tcr_pkg::CH2_COMP_POL_BIT], enpol_q[tcr_pkg::CH2_POL_BIT]},
                    pick_src(ch2_direction_select_q, {in2_prev_q, input_pin2},
                             {in1_prev_q, input_pin1}, {trig_prev_q, trigger_in}));

    always_ff @(posedge clock) begin
        if (reset) begin
            in1_prev_q <= 1'b0;
            in2_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            in1_prev_q <= input_pin1;
            in2_prev_q <= input_pin2;
            trig_prev_q <= trigger_in;
        end
    end

    // Value registers: captured in input mode, software compare value in output mode
    always_ff @(posedge clock) begin
        if (reset) begin
            ch1_value_q <= tcr_pkg::ZERO16;
            ch2_value_q <= tcr_pkg::ZERO16;
        end else begin
            if (cap1) begin
                ch1_value_q <= count_q;
            end else if (wr_go && address == tcr_pkg::OFF_CH1_VALUE
                         && ch1_direction_select_q == tcr_pkg::DIR_OUTPUT) begin
                ch1_value_q <= merge16(ch1_value_q, writedata, byteenable);
            end
            if (cap2) begin
                ch2_value_q <= count_q;
            end else if (wr_go && address == tcr_pkg::OFF_CH2_VALUE
                         && ch2_direction_select_q == tcr_pkg::DIR_OUTPUT) begin
                ch2_value_q <= merge16(ch2_value_q, writedata, byteenable);
            end
        end
    end

    // Compare outputs: reference active while counter below value
    assign ref1 = count_q < ch1_value_q;
    assign ref2 = count_q < ch2_value_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            out1_q <= 1'b0;
            out1n_q <= 1'b0;
            out2_q <= 1'b0;
        end else begin
            out1_q <= (ch1_direction_select_q == tcr_pkg::DIR_OUTPUT)
                && enpol_q[tcr_pkg::CH1_EN_BIT]
                && (ref1 ^ enpol_q[tcr_pkg::CH1_POL_BIT]);
            out1n_q <= (ch1_direction_select_q == tcr_pkg::DIR_OUTPUT)
                && enpol_q[tcr_pkg::CH1_COMP_EN_BIT]
                && (!ref1 ^ enpol_q[tcr_pkg::CH1_COMP_POL_BIT]);
            out2_q <= (ch2_direction_select_q == tcr_pkg::DIR_OUTPUT)
                && enpol_q[tcr_pkg::CH2_EN_BIT]
                && (ref2 ^ enpol_q[tcr_pkg::CH2_POL_BIT]);
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    assign events = {cap2, cap1, update_event};

    always_ff @(posedge clock) begin
        if (reset) begin
            status_q <= '0;
        end else if (wr_go && address == tcr_pkg::OFF_IRQ_STATUS && byteenable[0]) begin
            status_q <= (status_q & ~writedata[tcr_pkg::STAT_WIDTH-1:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign ch1_compare_out = out1_q;
    assign ch1_compare_out_n = out1n_q;
    assign ch2_compare_out = out2_q;
    assign irq = irq_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence enpol_write_s;
        wr_go && address == tcr_pkg::OFF_ENABLE_POLARITY && byteenable[0];
    endsequence

    sequence ch1_rise_s;
        !in1_prev_q && input_pin1;
    endsequence

    out_gate_a: assert property (
        (ch1_direction_select_q == tcr_pkg::DIR_OUTPUT && !enpol_q[tcr_pkg::CH1_EN_BIT])
        |=> !ch1_compare_out)
        else $error("ch1 output active while disabled");

    cap_block_a: assert property (
        (ch1_direction_select_q != tcr_pkg::DIR_OUTPUT && !enpol_q[tcr_pkg::CH1_EN_BIT])
        |=> $stable(ch1_value_q))
        else $error("ch1 captured while capture disabled");

    out_level_a: assert property (
        (ch1_direction_select_q == tcr_pkg::DIR_OUTPUT && enpol_q[tcr_pkg::CH1_EN_BIT])
        |=> ch1_compare_out == ($past(ref1) ^ $past(enpol_q[tcr_pkg::CH1_POL_BIT])))
        else $error("ch1 output level wrong");

    rise_capture_a: assert property (
        (ch1_direction_select_q == tcr_pkg::DIR_OWN_PIN && enpol_q[tcr_pkg::CH1_EN_BIT]
         && enpol_q[tcr_pkg::CH1_COMP_POL_BIT] == 1'b0
         && enpol_q[tcr_pkg::CH1_POL_BIT] == 1'b0) ##0 ch1_rise_s
        |=> ch1_value_q == $past(count_q) && status_q[tcr_pkg::STAT_CAP1_BIT])
        else $error("rising edge not captured");

    both_edge_a: assert property (
        (ch1_direction_select_q == tcr_pkg::DIR_OWN_PIN && enpol_q[tcr_pkg::CH1_EN_BIT]
         && enpol_q[tcr_pkg::CH1_COMP_POL_BIT] && enpol_q[tcr_pkg::CH1_POL_BIT]
         && in1_prev_q && !input_pin1)
        |=> ch1_value_q == $past(count_q))
        else $error("falling edge missed in both-edge sense");

    comp_gate_a: assert property (
        !enpol_q[tcr_pkg::CH1_COMP_EN_BIT] |=> !ch1_compare_out_n)
        else $error("complementary output active while disabled");

    comp_lock_a: assert property (
        (lock_q >= tcr_pkg::LOCK_LEVEL_2) ##0 enpol_write_s
        |=> $stable(enpol_q[tcr_pkg::CH1_COMP_POL_BIT]))
        else $error("locked complementary polarity changed");

    tick_rate_a: assert property (
        (counting && prescale_cnt_q < prescale_value_q
         && !(wr_go && address == tcr_pkg::OFF_COUNTER))
        |=> $stable(count_q))
        else $error("counter advanced between prescaler ticks");

    reload_zero_a: assert property (
        (reload_value_q == tcr_pkg::ZERO16 && !(wr_go && address == tcr_pkg::OFF_COUNTER))
        |=> $stable(count_q))
        else $error("counter moved with zero reload");

    rep_reload_a: assert property (
        update_event |=> repeat_left_q == $past(repeat_count_value_q)
                         && status_q[tcr_pkg::STAT_UPDATE_BIT])
        else $error("repetition not restarted at update");

    rep_defer_a: assert property (
        (wr_go && address == tcr_pkg::OFF_REPETITION && !update_event && !wrap)
        |=> $stable(repeat_left_q))
        else $error("repetition value applied before update");
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock, reset, read, write, waitrequest, irq, input_pin1, input_pin2, trigger_in;
    logic ch1_compare_out, ch1_compare_out_n, ch2_compare_out;
    logic irq_prev = 1'b0;
    logic [7:0] address;
    logic [31:0] writedata, readdata, v;
    logic [3:0] byteenable;
    logic [7:0] sense [3] = '{8'h01, 8'h03, 8'h0B};
    logic [31:0] exp_q [$];
    integer seed;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0, t1;
    int rise_t [$];

    tcr_timer i_tcr_timer (.clock(clock), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .input_pin1(input_pin1), .input_pin2(input_pin2),
        .trigger_in(trigger_in), .ch1_compare_out(ch1_compare_out),
        .ch1_compare_out_n(ch1_compare_out_n), .ch2_compare_out(ch2_compare_out), .irq(irq));
    tcr_pin_model i_tcr_pin_model (.clock(clock), .input_pin1(input_pin1),
        .input_pin2(input_pin2), .trigger_in(trigger_in));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Request held until waitrequest is sampled low, released right after that edge
    task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= is_wr;
        read <= !is_wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check("waitrequest", 32'h0, 32'h1);
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Waits for the next interrupt rise, then clears the update flag
    task automatic next_rise(output int t);
        int n;
        n = 0;
        while (rise_t.size() == 0 && n < 500) begin
            @(posedge clock);
            n++;
        end
        if (rise_t.size() == 0) check("irq_rise", 32'h1, 32'h0);
        t = (rise_t.size() == 0) ? 0 : rise_t.pop_front();
        wr(tcr_pkg::OFF_IRQ_STATUS, 32'h1);
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        irq_prev <= irq;
        if (irq === 1'b1 && irq_prev === 1'b0) rise_t.push_back(cyc);
        if (read === 1'b1 && waitrequest === 1'b0) begin
            check("readdata", exp_q.pop_front(), readdata);
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end

    initial begin
        seed = 32'hE83D00BD;
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'hF;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rd(tcr_pkg::OFF_ENABLE_POLARITY, 32'h0);
        rd(tcr_pkg::OFF_COUNTER, 32'h0);
        rd(tcr_pkg::OFF_PRESCALER, 32'h0);
        rd(tcr_pkg::OFF_RELOAD, 32'hFFFF);
        rd(tcr_pkg::OFF_REPETITION, 32'h0);
        rd(8'h40, 32'h0);
        wr(tcr_pkg::OFF_ENABLE_POLARITY, 32'hFFFFFFFF);
        rd(tcr_pkg::OFF_ENABLE_POLARITY, 32'hBF);
        wr(tcr_pkg::OFF_REPETITION, 32'hFFFF);
        rd(tcr_pkg::OFF_REPETITION, 32'hFF);
        for (int i = 2; i < 4; i++) begin
            wr(tcr_pkg::OFF_CONTROL, 32'(i) << 8);
            wr(tcr_pkg::OFF_ENABLE_POLARITY, 32'h0);
            rd(tcr_pkg::OFF_ENABLE_POLARITY, 32'h88);
        end
        wr(tcr_pkg::OFF_CONTROL, 32'h0);
        // Counter stopped at 0: ch1 reference high (0 < 5), ch2 reference low (0 < 0)
        wr(tcr_pkg::OFF_CH1_VALUE, 32'h5);
        for (int i = 0; i < 16; i++) begin
            v = $random(seed) & 32'hBF;
            wr(tcr_pkg::OFF_ENABLE_POLARITY, v);
            repeat (3) @(posedge clock);
            check("ch1_compare_out", 32'(v[0] & ~v[1]), 32'(ch1_compare_out));
            check("ch1_compare_out_n", 32'(v[2] & v[3]), 32'(ch1_compare_out_n));
            check("ch2_compare_out", 32'(v[4] & v[5]), 32'(ch2_compare_out));
        end
        wr(tcr_pkg::OFF_ENABLE_POLARITY, 32'h0);
        wr(tcr_pkg::OFF_PRESCALER, 32'h1);
        wr(tcr_pkg::OFF_RELOAD, 32'h3);
        wr(tcr_pkg::OFF_REPETITION, 32'h2);
        wr(tcr_pkg::OFF_IRQ_MASK, 32'h1);
        wr(tcr_pkg::OFF_CONTROL, 32'h1);
        // First update comes at an unknown phase, so only later spacings are measured
        next_rise(t0);
        next_rise(t0);
        next_rise(t1);
        check("update_period", 32'h18, 32'(t1 - t0));
        wr(tcr_pkg::OFF_REPETITION, 32'h0);
        next_rise(t0);
        check("update_period", 32'h18, 32'(t0 - t1));
        next_rise(t1);
        check("update_period", 32'h8, 32'(t1 - t0));
        wr(tcr_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (20) @(posedge clock);
        check("irq", 32'h0, 32'(irq));
        rd(tcr_pkg::OFF_IRQ_STATUS, 32'h1);
        wr(tcr_pkg::OFF_CONTROL, 32'h0);
        wr(tcr_pkg::OFF_IRQ_STATUS, 32'h7);
        wr(tcr_pkg::OFF_RELOAD, 32'h0);
        wr(tcr_pkg::OFF_CONTROL, 32'h1);
        wr(tcr_pkg::OFF_COUNTER, 32'h7);
        repeat (10) @(posedge clock);
        rd(tcr_pkg::OFF_COUNTER, 32'h7);
        wr(tcr_pkg::OFF_CONTROL, 32'h0);
        wr(tcr_pkg::OFF_CH_MODE, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(tcr_pkg::OFF_ENABLE_POLARITY, (i < 3) ? 32'(sense[i]) : 32'h0);
            wr(tcr_pkg::OFF_COUNTER, 32'h1110 + 32'(i));
            i_tcr_pin_model.edge1(1'b1);
            wr(tcr_pkg::OFF_COUNTER, 32'h2220 + 32'(i));
            i_tcr_pin_model.edge1(1'b0);
            rd(tcr_pkg::OFF_CH1_VALUE, (i == 0) ? 32'h1110 : 32'h2220 + 32'((i < 3) ? i : 2));
        end
        rd(tcr_pkg::OFF_IRQ_STATUS, 32'h2);
        // Cross-mapped pins, then the trigger source
        wr(tcr_pkg::OFF_CH_MODE, 32'h0202);
        wr(tcr_pkg::OFF_ENABLE_POLARITY, 32'h11);
        wr(tcr_pkg::OFF_COUNTER, 32'h3330);
        i_tcr_pin_model.edge_on(2, 1'b1);
        rd(tcr_pkg::OFF_CH1_VALUE, 32'h3330);
        wr(tcr_pkg::OFF_COUNTER, 32'h4440);
        i_tcr_pin_model.edge_on(1, 1'b1);
        wr(tcr_pkg::OFF_ENABLE_POLARITY, 32'h0);
        wr(tcr_pkg::OFF_CH_MODE, 32'h0203);
        wr(tcr_pkg::OFF_ENABLE_POLARITY, 32'h01);
        wr(tcr_pkg::OFF_COUNTER, 32'h5550);
        i_tcr_pin_model.edge_on(3, 1'b1);
        rd(tcr_pkg::OFF_CH1_VALUE, 32'h5550);
        rd(tcr_pkg::OFF_CH2_VALUE, 32'h4440);
        rd(tcr_pkg::OFF_IRQ_STATUS, 32'h6);
        end_of_test();
    end
endmodule
`default_nettype wire

//--- testbench/tcr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_pin_model (
    input wire logic clock, // Timer clock
    output logic input_pin1, // Timer input 1
    output logic input_pin2, // Timer input 2
    output logic trigger_in // Internal trigger source
);
    initial begin
        input_pin1 = 1'b0;
        input_pin2 = 1'b0;
        trigger_in = 1'b0;
    end
    // Moves pin 1 just after an edge and holds it, so a rising or falling edge is seen
    task automatic edge1(input logic v);
        @(posedge clock);
        input_pin1 <= v;
        repeat (3) @(posedge clock);
    endtask
    // Same, for a chosen source: 1 pin 1, 2 pin 2, 3 trigger
    task automatic edge_on(input int sel, input logic v);
        @(posedge clock);
        if (sel == 2) begin
            input_pin2 <= v;
        end else if (sel == 3) begin
            trigger_in <= v;
        end else begin
            input_pin1 <= v;
        end
        repeat (3) @(posedge clock);
    endtask
endmodule
`default_nettype wire
